// File: design/sctc_consts.svh
// constants for the recovery and feature control decoder
`ifndef SCTC_CONSTS_SVH
`define SCTC_CONSTS_SVH
`define SCTC_ACT_RECOVERY 16'h0003
`define SCTC_ACT_FEATURE 16'h0004
`define SCTC_FN_SET 16'h0001
`define SCTC_FN_GET 16'h0002
`define SCTC_FN_FLAGS 16'h0003
`define SCTC_SEL_READ 16'h0001
`define SCTC_SEL_WRITE 16'h0002
`define SCTC_FEAT_WCACHE 16'h0001
`define SCTC_WC_HOST 16'h0001
`define SCTC_WC_ON 16'h0002
`define SCTC_WC_OFF 16'h0003
`define SCTC_WC_DEFAULT 16'h0001
`define SCTC_LIMIT_MIN 16'h0041
`define SCTC_LIMIT_DEFAULT 16'h0000
`define SCTC_UNIT_MS 100
`define SCTC_CLK_MHZ 125
`define SCTC_UNIT_CYCLES (`SCTC_UNIT_MS * 1000 * `SCTC_CLK_MHZ)
`define SCTC_ERR_OK 8'h00
`define SCTC_ERR_ABORT 8'h04
`define SCTC_STS_OK 8'h50
`define SCTC_STS_ERR 8'h51
`define SCTC_FLAG_PERSIST 0
`endif

// File: design/sctc_pkg.sv
// types for the recovery and feature control decoder
package sctc_pkg;
    typedef enum logic [2:0] {
        SCTC_IDLE = 3'b001,
        SCTC_RUN = 3'b010,
        SCTC_EXPIRED = 3'b100
    } sctc_timer_state_type;
endpackage : sctc_pkg

// File: design/sctc_recovery_timer.sv
// recovery time limit watchdog for one command
`timescale 1ns/100ps
`include "sctc_consts.svh"
module sctc_recovery_timer #(
    parameter int UNIT_CYCLES = `SCTC_UNIT_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [15:0] i_limit,
    output logic o_expired
);
    sctc_pkg::sctc_timer_state_type state_q;
    logic [31:0] tick_q;
    logic [15:0] units_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= sctc_pkg::SCTC_IDLE;
            tick_q <= 32'h0;
            units_q <= 16'h0;
        end else begin
            case (state_q)
                sctc_pkg::SCTC_IDLE: begin
                    // a zero limit disables the time-out
                    if (i_start && i_limit != `SCTC_LIMIT_DEFAULT) begin
                        state_q <= sctc_pkg::SCTC_RUN;
                        tick_q <= 32'h0;
                        units_q <= 16'h0;
                    end
                end
                sctc_pkg::SCTC_RUN: begin
                    if (i_stop) begin
                        state_q <= sctc_pkg::SCTC_IDLE;
                    end else if (tick_q == 32'(UNIT_CYCLES - 1)) begin
                        tick_q <= 32'h0;
                        units_q <= units_q + 16'h1;
                        if (units_q + 16'h1 >= i_limit) begin
                            state_q <= sctc_pkg::SCTC_EXPIRED;
                        end
                    end else begin
                        tick_q <= tick_q + 32'h1;
                    end
                end
                sctc_pkg::SCTC_EXPIRED: begin
                    if (i_stop) begin
                        state_q <= sctc_pkg::SCTC_IDLE;
                    end
                end
                default: state_q <= sctc_pkg::SCTC_IDLE;
            endcase
        end
    end

    assign o_expired = (state_q == sctc_pkg::SCTC_EXPIRED);
endmodule : sctc_recovery_timer

// File: design/sctc_control.sv
// recovery and feature control command decoder with command watchdogs
//
// Contract
// - action 0003h is recovery control; function 0001h stores, 0002h returns a limit
// - selection 0001h is the read timer, 0002h the write timer
// - the limit in word 3 counts 100 ms units
// - a stored limit below 65 aborts the command
// - limit return gives error 00h, status 50h, limit low byte in sector count
// - limit return gives the high byte in sector number; otherwise reserved
// - non-queued commands: timers bound time to completion at the host
// - in-order queued commands: timers start when execution begins
// - no timer for streaming or out-of-order queued commands
// - limits are volatile and default to 0, which disables the time-out
// - action 0004h is feature control: set, get state, get option flags
// - option bit 0 set keeps the new state across power cycles; only the write cache state is written to the store
// - option bit 0 clear is volatile; hard reset restores stored value
// - state return gives low byte in sector count, high in sector number
// - flags return gives flags bytes likewise; other functions leave reserved
// - write cache feature: 0001h host governed, 0002h on, 0003h off
`timescale 1ns/100ps
`include "sctc_consts.svh"
module sctc_control (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_key_valid,
    input wire logic [15:0] i_key_action,
    input wire logic [15:0] i_key_function,
    input wire logic [15:0] i_key_word2,
    input wire logic [15:0] i_key_word3,
    input wire logic [15:0] i_key_word4,
    input wire logic i_hard_reset,
    input wire logic [15:0] i_nv_wcache_state,
    output logic o_nv_write,
    output logic [15:0] o_nv_wcache_state,
    input wire logic i_host_wcache_en,
    output logic o_wcache_en,
    input wire logic i_cmd_arrive,
    input wire logic i_cmd_exec_start,
    input wire logic i_cmd_done,
    input wire logic i_cmd_is_write,
    input wire logic i_cmd_queued,
    input wire logic i_cmd_streaming,
    input wire logic i_out_of_order,
    output logic o_read_timeout,
    output logic o_write_timeout,
    output logic o_result_valid,
    output logic [7:0] o_result_error,
    output logic [7:0] o_result_sector_count,
    output logic [7:0] o_result_sector_number,
    output logic [7:0] o_result_status
);
    logic [15:0] read_limit_q;
    logic [15:0] write_limit_q;
    logic [15:0] wcache_state_q;
    logic [15:0] option_flags_q;
    logic [15:0] reorder_state_q;
    logic loaded_q;
    logic valid_q;
    logic [7:0] error_q;
    logic [7:0] count_q;
    logic [7:0] number_q;
    logic [7:0] status_q;
    logic nv_write_q;
    logic [15:0] nv_state_q;

    logic is_rec;
    logic is_feat;
    logic rec_ok;
    logic feat_ok;
    logic limit_ok;
    logic set_rec;
    logic set_feat;
    logic [15:0] rec_value;
    logic [15:0] feat_value;
    logic timed_cmd;
    logic tmr_start;
    logic tmr_stop;
    logic read_exp;
    logic write_exp;

    function automatic logic sctc_code_in(input logic [15:0] code, input logic [15:0] hi);
        sctc_code_in = (code >= 16'h0001) && (code <= hi);
    endfunction : sctc_code_in

    assign is_rec = (i_key_action == `SCTC_ACT_RECOVERY);
    assign is_feat = (i_key_action == `SCTC_ACT_FEATURE);
    assign rec_ok = is_rec && sctc_code_in(i_key_function, `SCTC_FN_GET)
        && sctc_code_in(i_key_word2, `SCTC_SEL_WRITE);
    assign limit_ok = (i_key_word3 >= `SCTC_LIMIT_MIN);
    assign set_rec = i_key_valid && rec_ok && i_key_function == `SCTC_FN_SET && limit_ok;
    assign rec_value = (i_key_word2 == `SCTC_SEL_READ) ? read_limit_q : write_limit_q;
    assign feat_ok = is_feat && sctc_code_in(i_key_function, `SCTC_FN_FLAGS)
        && sctc_code_in(i_key_word2, 16'h0002)
        && (i_key_function != `SCTC_FN_SET
            || (i_key_word2 == `SCTC_FEAT_WCACHE && sctc_code_in(i_key_word3, `SCTC_WC_OFF))
            || (i_key_word2 != `SCTC_FEAT_WCACHE && sctc_code_in(i_key_word3, 16'h0002)));
    assign set_feat = i_key_valid && feat_ok && i_key_function == `SCTC_FN_SET;
    assign feat_value = (i_key_word2 == `SCTC_FEAT_WCACHE) ? wcache_state_q : reorder_state_q;

    // recovery limits live only in flip-flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            read_limit_q <= `SCTC_LIMIT_DEFAULT;
            write_limit_q <= `SCTC_LIMIT_DEFAULT;
        end else if (set_rec) begin
            if (i_key_word2 == `SCTC_SEL_READ) begin
                read_limit_q <= i_key_word3;
            end else begin
                write_limit_q <= i_key_word3;
            end
        end
    end

    // stored setting is caught once after reset release, and again on hard reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            loaded_q <= 1'b0;
            wcache_state_q <= `SCTC_WC_DEFAULT;
            reorder_state_q <= 16'h0001;
            option_flags_q <= 16'h0000;
        end else if (!loaded_q || i_hard_reset) begin
            loaded_q <= 1'b1;
            wcache_state_q <= sctc_code_in(i_nv_wcache_state, `SCTC_WC_OFF)
                ? i_nv_wcache_state : `SCTC_WC_DEFAULT;
            reorder_state_q <= 16'h0001;
        end else if (set_feat) begin
            option_flags_q <= {15'h0, i_key_word4[`SCTC_FLAG_PERSIST]};
            if (i_key_word2 == `SCTC_FEAT_WCACHE) begin
                wcache_state_q <= i_key_word3;
            end else begin
                reorder_state_q <= i_key_word3;
            end
        end
    end

    // persistent write cache request writes the store
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            nv_write_q <= 1'b0;
            nv_state_q <= `SCTC_WC_DEFAULT;
        end else begin
            nv_write_q <= set_feat && i_key_word2 == `SCTC_FEAT_WCACHE
                && i_key_word4[`SCTC_FLAG_PERSIST];
            if (set_feat && i_key_word2 == `SCTC_FEAT_WCACHE) begin
                nv_state_q <= i_key_word3;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wcache_en <= 1'b0;
        end else begin
            case (wcache_state_q)
                `SCTC_WC_ON: o_wcache_en <= 1'b1;
                `SCTC_WC_OFF: o_wcache_en <= 1'b0;
                default: o_wcache_en <= i_host_wcache_en;
            endcase
        end
    end

    // command result registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            valid_q <= 1'b0;
            error_q <= `SCTC_ERR_OK;
            count_q <= 8'h00;
            number_q <= 8'h00;
            status_q <= `SCTC_STS_OK;
        end else begin
            valid_q <= i_key_valid;
            if (i_key_valid) begin
                count_q <= 8'h00;
                number_q <= 8'h00;
                if ((rec_ok && (i_key_function != `SCTC_FN_SET || limit_ok)) || feat_ok) begin
                    error_q <= `SCTC_ERR_OK;
                    status_q <= `SCTC_STS_OK;
                    if (is_rec && i_key_function == `SCTC_FN_GET) begin
                        count_q <= rec_value[7:0];
                        number_q <= rec_value[15:8];
                    end else if (is_feat && i_key_function == `SCTC_FN_GET) begin
                        count_q <= feat_value[7:0];
                        number_q <= feat_value[15:8];
                    end else if (is_feat && i_key_function == `SCTC_FN_FLAGS) begin
                        count_q <= option_flags_q[7:0];
                        number_q <= option_flags_q[15:8];
                    end
                end else begin
                    error_q <= `SCTC_ERR_ABORT;
                    status_q <= `SCTC_STS_ERR;
                end
            end
        end
    end

    // timers watch only commands that qualify; queued ones start at execution
    assign timed_cmd = !i_cmd_streaming && !(i_cmd_queued && i_out_of_order);
    assign tmr_start = timed_cmd && (i_cmd_queued ? i_cmd_exec_start : i_cmd_arrive);
    assign tmr_stop = i_cmd_done;

    sctc_recovery_timer u_read_timer (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_start(tmr_start && !i_cmd_is_write),
        .i_stop(tmr_stop),
        .i_limit(read_limit_q),
        .o_expired(read_exp)
    );

    sctc_recovery_timer u_write_timer (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_start(tmr_start && i_cmd_is_write),
        .i_stop(tmr_stop),
        .i_limit(write_limit_q),
        .o_expired(write_exp)
    );

    assign o_read_timeout = read_exp;
    assign o_write_timeout = write_exp;
    assign o_result_valid = valid_q;
    assign o_result_error = error_q;
    assign o_result_sector_count = count_q;
    assign o_result_sector_number = number_q;
    assign o_result_status = status_q;
    assign o_nv_write = nv_write_q;
    assign o_nv_wcache_state = nv_state_q;
endmodule : sctc_control

// File: testbench/sctc_monitor.sv
// port assertions for the recovery and feature control decoder
`timescale 1ns/100ps
module sctc_monitor (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_key_valid,
    input wire logic [15:0] i_key_action,
    input wire logic [15:0] i_key_function,
    input wire logic [15:0] i_key_word2,
    input wire logic [15:0] i_key_word3,
    input wire logic i_cmd_done,
    input wire logic o_read_timeout,
    input wire logic o_wcache_en,
    input wire logic o_result_valid,
    input wire logic [7:0] o_result_error,
    input wire logic [7:0] o_result_sector_number,
    input wire logic [7:0] o_result_status
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire lim = i_key_valid && i_key_action == 16'h0003 && i_key_word2 inside {16'h0001, 16'h0002};
    wire feat = i_key_valid && i_key_action == 16'h0004;
    wire wc_set = feat && i_key_function == 16'h0001 && i_key_word2 == 16'h0001;
    sequence force_on;
        wc_set && i_key_word3 == 16'h0002 ##1 o_result_valid;
    endsequence
    sequence force_off;
        wc_set && i_key_word3 == 16'h0003 ##1 o_result_valid;
    endsequence
    answer_once_a: assert property (i_key_valid |=> o_result_valid) else $error("no answer");
    no_spurious_a: assert property (!i_key_valid |=> !o_result_valid) else $error("stray answer");
    get_ok_a: assert property (lim && i_key_function == 16'h0002 |=>
        o_result_error == 8'h00 && o_result_status == 8'h50) else $error("get not ok");
    short_abort_a: assert property (lim && i_key_function == 16'h0001 && i_key_word3 < 16'h0041 |=>
        o_result_error == 8'h04 && o_result_status == 8'h51) else $error("short limit taken");
    bad_fn_a: assert property (i_key_valid && i_key_function > 16'h0003 |=> o_result_status == 8'h51)
        else $error("bad function taken");
    flags_high_a: assert property (feat && i_key_function == 16'h0003 |=> o_result_sector_number == 8'h00)
        else $error("flags high byte");
    done_clear_a: assert property (i_cmd_done |=> !o_read_timeout) else $error("timeout held");
    cache_on_a: assert property (force_on |-> ##[1:2] o_wcache_en) else $error("cache not on");
    cache_off_a: assert property (force_off |-> ##[1:2] !o_wcache_en) else $error("cache not off");
endmodule : sctc_monitor

// File: testbench/sctc_host_model.sv
// host side model that issues key sectors
`timescale 1ns/100ps
module sctc_host_model (
    input wire logic i_clk,
    output logic o_key_valid,
    output logic [15:0] o_a,
    output logic [15:0] o_f,
    output logic [15:0] o_w2,
    output logic [15:0] o_w3,
    output logic [15:0] o_w4
);
    initial begin
        o_key_valid = 1'b0;
        {o_a, o_f, o_w2, o_w3, o_w4} = '0;
    end
    task automatic send(input logic [15:0] a, f, w2, w3, w4);
        @(negedge i_clk);
        o_key_valid = 1'b1;
        {o_a, o_f, o_w2, o_w3, o_w4} = {a, f, w2, w3, w4};
        @(negedge i_clk);
        o_key_valid = 1'b0;
        {o_a, o_f, o_w2, o_w3, o_w4} = ~{a, f, w2, w3, w4};
    endtask : send
endmodule : sctc_host_model

// File: testbench/tb.sv
// testbench for the recovery and feature control decoder
`timescale 1ns/100ps
module tb;
    logic i_clk = 0, i_nrst = 0, i_hard_reset = 0, i_host_wcache_en = 0, i_cmd_arrive = 0, i_cmd_exec_start = 0;
    logic i_cmd_done = 0, i_cmd_is_write = 0, i_cmd_queued = 0, i_cmd_streaming = 0, i_out_of_order = 0;
    logic [15:0] i_nv_wcache_state = 16'h0001, ka, kf, k2, k3, k4;
    logic kv, o_nv_write, o_wcache_en, o_read_timeout, o_write_timeout, o_result_valid;
    logic [15:0] o_nv_wcache_state;
    logic [7:0] o_result_error, o_result_sector_count, o_result_sector_number, o_result_status;
    int fail_count = 0, samples_checked = 0, n;
    always #4 i_clk = ~i_clk;
    defparam dut.u_read_timer.UNIT_CYCLES = 10;
    defparam dut.u_write_timer.UNIT_CYCLES = 10;
    sctc_host_model host (.i_clk(i_clk), .o_key_valid(kv), .o_a(ka), .o_f(kf), .o_w2(k2), .o_w3(k3), .o_w4(k4));
    sctc_control dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_key_valid(kv), .i_key_action(ka), .i_key_function(kf),
        .i_key_word2(k2), .i_key_word3(k3), .i_key_word4(k4), .i_hard_reset(i_hard_reset),
        .i_nv_wcache_state(i_nv_wcache_state), .o_nv_write(o_nv_write), .o_nv_wcache_state(o_nv_wcache_state),
        .i_host_wcache_en(i_host_wcache_en), .o_wcache_en(o_wcache_en), .i_cmd_arrive(i_cmd_arrive),
        .i_cmd_exec_start(i_cmd_exec_start), .i_cmd_done(i_cmd_done), .i_cmd_is_write(i_cmd_is_write),
        .i_cmd_queued(i_cmd_queued), .i_cmd_streaming(i_cmd_streaming), .i_out_of_order(i_out_of_order),
        .o_read_timeout(o_read_timeout), .o_write_timeout(o_write_timeout), .o_result_valid(o_result_valid),
        .o_result_error(o_result_error), .o_result_sector_count(o_result_sector_count),
        .o_result_sector_number(o_result_sector_number), .o_result_status(o_result_status));
    task automatic chk(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one key sector; the answer is judged at the falling edge after the key is taken, while valid stands
    task automatic req(input logic [15:0] a, f, w2, w3, w4, input logic [7:0] err, input logic [15:0] val);
        host.send(a, f, w2, w3, w4);
        chk(o_result_valid, 1'b1);
        chk(o_result_error, err);
        chk(o_result_status, err == 8'h00 ? 8'h50 : 8'h51);
        if (err == 8'h00) chk({o_result_sector_number, o_result_sector_count}, val);
    endtask : req
    task automatic t_limits;
        req(3, 2, 1, 0, 0, 8'h00, 16'h0000);
        req(3, 2, 2, 0, 0, 8'h00, 16'h0000);
        req(3, 1, 1, 16'h0041, 0, 8'h00, 0);
        req(3, 1, 2, 16'h0040, 0, 8'h04, 0);
        req(3, 2, 1, 0, 0, 8'h00, 16'h0041);
        req(3, 2, 2, 0, 0, 8'h00, 16'h0000);
        req(3, 1, 2, 16'h1234, 0, 8'h00, 0);
        req(3, 2, 2, 0, 0, 8'h00, 16'h1234);
        req(3, 1, 3, 16'h0100, 0, 8'h04, 0);
        req(3, 5, 1, 0, 0, 8'h04, 0);
        $display("test limits done");
    endtask : t_limits
    task automatic t_features;
        req(4, 2, 1, 0, 0, 8'h00, 16'h0001);
        req(4, 1, 1, 2, 0, 8'h00, 0);
        chk(o_nv_write, 1'b0);
        repeat (2) @(negedge i_clk);
        chk(o_wcache_en, 1'b1);
        i_host_wcache_en = 1'b1;
        req(4, 1, 1, 3, 1, 8'h00, 0);
        chk(o_nv_write, 1'b1);
        repeat (2) @(negedge i_clk);
        chk(o_wcache_en, 1'b0);
        chk(o_nv_wcache_state, 16'h0003);
        req(4, 3, 1, 0, 0, 8'h00, 16'h0001);
        req(4, 1, 1, 1, 0, 8'h00, 0);
        chk(o_nv_write, 1'b0);
        repeat (2) @(negedge i_clk);
        chk(o_wcache_en, 1'b1);
        req(4, 1, 1, 4, 0, 8'h04, 0);
        req(4, 1, 5, 1, 0, 8'h04, 0);
        i_nv_wcache_state = 16'h0003;
        i_hard_reset = 1'b1;
        @(negedge i_clk);
        i_hard_reset = 1'b0;
        req(4, 2, 1, 0, 0, 8'h00, 16'h0003);
        $display("test features done");
    endtask : t_features
    // limits of 65 units: plain, in-order queued and plain write time out, streaming and out-of-order do not
    task automatic t_timer;
        req(3, 1, 2, 16'h0041, 0, 8'h00, 16'h0000);
        for (int m = 0; m < 5; m++) begin
            @(negedge i_clk);
            {i_cmd_queued, i_cmd_streaming, i_out_of_order} = {m[1], m == 1, m == 2};
            i_cmd_is_write = (m == 4);
            i_cmd_arrive = 1'b1;
            @(negedge i_clk);
            i_cmd_arrive = 1'b0;
            if (m[1]) begin
                repeat (100) @(negedge i_clk);
                i_cmd_exec_start = 1'b1;
                @(negedge i_clk);
                i_cmd_exec_start = 1'b0;
            end
            n = 0;
            while (!(m == 4 ? o_write_timeout : o_read_timeout) && n < 800) begin
                @(negedge i_clk);
                n++;
            end
            chk(n >= 640 && n <= 660, m == 0 || m >= 3);
            chk(m == 4 ? o_read_timeout : o_write_timeout, 1'b0);
            i_cmd_done = 1'b1;
            @(negedge i_clk);
            i_cmd_done = 1'b0;
            chk(o_read_timeout | o_write_timeout, 1'b0);
        end
        $display("test timer done");
    endtask : t_timer
    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (5) @(negedge i_clk);
        i_nrst = 1'b1;
        repeat (2) @(negedge i_clk);
        t_limits();
        t_features();
        t_timer();
        close_out();
    end
endmodule : tb
bind sctc_control sctc_monitor mon (.i_clk(i_clk), .i_nrst(i_nrst), .i_key_valid(i_key_valid),
    .i_key_action(i_key_action), .i_key_function(i_key_function), .i_key_word2(i_key_word2),
    .i_key_word3(i_key_word3), .i_cmd_done(i_cmd_done), .o_read_timeout(o_read_timeout),
    .o_wcache_en(o_wcache_en), .o_result_valid(o_result_valid), .o_result_error(o_result_error),
    .o_result_sector_number(o_result_sector_number), .o_result_status(o_result_status));
